// ==== hdl/dcmc_top.v ====
// Operation
// R1: After reset every channel is a powered-down current output with its pin in high impedance.
// R2: A channel's two-bit power mode of 00 enables it and any other value powers it down.
// R3: A powered-down channel floats in current mode and is pulled to ground in voltage mode.
// R4: A per-channel type bit selects voltage output when one and current output when zero.
// R5: The host must zero a channel's code before switching its output type.
// R6: Bit 2 of the range register sets gain two for every voltage channel, gain one when clear.
// R7: Each 16-bit code is straight binary and drives the converter unchanged.
// R8: Power-down keeps all settings readable and writable, but the pin ignores code changes.
// R9: Bit 0 of the reference register enables the internal reference, external after reset.
// R10: A monitor select write with an invalid value is ignored and the old value stays.
// R11: The monitor output is powered down after reset, select value zero.
// R12: Monitor value 3n+1, 3n+2, 3n+3 pick voltage, current, supply of channel n; 25 temp, 26 ground.
// R13: Monitor select values above 26 are invalid.
//
// Local design decisions: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`include "dcmc_consts.vh"
module dcmc_top (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  output reg [7:0] out_enable,
  output reg [7:0] out_voltage_mode,
  output reg [7:0] out_pulldown,
  output reg [127:0] out_code,
  output reg gain_double,
  output reg internal_ref_en,
  output reg monitor_enable,
  output reg [4:0] monitor_output
);

  // Stored configuration
  reg [15:0] channel_power_mode;
  reg [7:0] voltage_output_select;
  reg range_bit;
  reg ref_bit;
  reg [4:0] monitor_select_register;
  reg [127:0] code;

  // Bus front end state
  reg [11:0] addr_q;
  reg wr_q;
  reg rd_q;
  reg addr_phase;
  reg read_phase;

  // Register hits for the data-phase address
  reg hit_power;
  reg hit_vout;
  reg hit_range;
  reg hit_ref;
  reg hit_mon;
  reg hit_status;
  reg hit_code;
  reg [2:0] code_index;

  // Write strobes, one per register
  reg wr_power;
  reg wr_vout;
  reg wr_range;
  reg wr_ref;
  reg wr_mon;

  // Monitor select checking, read data and monitor enable
  reg mon_valid;
  reg [31:0] next_rdata;
  reg [15:0] code_word;
  reg [15:0] status_word;
  reg next_monitor_enable;

  // Source classes of the stored monitor select
  reg mon_src_channel;
  reg mon_src_temp;
  reg mon_src_ground;

  // Transfer qualifiers of the current address phase
  always @* begin
    addr_phase = hsel & hready & htrans[1];
    read_phase = addr_phase & ~hwrite;
  end

  // Data-phase direction flags
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= addr_phase & hwrite;
      rd_q <= read_phase;
    end
  end

  // Address of an accepted address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 12'h000;
    end else if (addr_phase) begin
      addr_q <= haddr;
    end
  end

  // One wait state on reads, so read data comes from settled registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
    end else if (read_phase) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  // Response is always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Address decode of the data-phase address
  always @* begin
    hit_power = 1'b0;
    hit_vout = 1'b0;
    hit_range = 1'b0;
    hit_ref = 1'b0;
    hit_mon = 1'b0;
    hit_status = 1'b0;
    hit_code = 1'b0;
    code_index = addr_q[4:2];
    if (addr_q == `DCMC_OFF_POWER_MODE) begin
      hit_power = 1'b1;
    end else if (addr_q == `DCMC_OFF_VOUT_SEL) begin
      hit_vout = 1'b1;
    end else if (addr_q == `DCMC_OFF_RANGE) begin
      hit_range = 1'b1;
    end else if (addr_q == `DCMC_OFF_REFERENCE) begin
      hit_ref = 1'b1;
    end else if (addr_q == `DCMC_OFF_MON_SEL) begin
      hit_mon = 1'b1;
    end else if (addr_q == `DCMC_OFF_STATUS) begin
      hit_status = 1'b1;
    end else if (addr_q >= `DCMC_OFF_CODE_BASE && addr_q <= `DCMC_OFF_CODE_LAST) begin
      hit_code = 1'b1;
    end
  end

  // Write strobes for the data phase
  always @* begin
    wr_power = wr_q & hit_power;
    wr_vout = wr_q & hit_vout;
    wr_range = wr_q & hit_range;
    wr_ref = wr_q & hit_ref;
    wr_mon = wr_q & hit_mon & mon_valid; // R10 R13
  end

  // Select values above the last source, upper bits included, are refused
  always @* begin
    mon_valid = (hwdata[31:5] == 27'h000_0000) && (hwdata[4:0] <= `DCMC_MON_LAST); // R10 R13
  end

  // Per-channel power modes, all powered down after reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_power_mode <= `DCMC_POWER_MODE_RST; // R1
    end else if (wr_power) begin
      channel_power_mode <= hwdata[15:0]; // R2 R8
    end
  end

  // Per-channel output type, current output after reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      voltage_output_select <= `DCMC_VOUT_SEL_RST; // R1 R4
    end else if (wr_vout) begin
      voltage_output_select <= hwdata[7:0]; // R4
    end
  end

  // Shared range bit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      range_bit <= `DCMC_RANGE_RST; // R6
    end else if (wr_range) begin
      range_bit <= hwdata[`DCMC_RANGE_BIT]; // R6
    end
  end

  // Reference source bit
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_bit <= `DCMC_REF_RST; // R9
    end else if (wr_ref) begin
      ref_bit <= hwdata[`DCMC_REF_SEL_BIT]; // R9
    end
  end

  // Monitor select, refused values keep the old one
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      monitor_select_register <= `DCMC_MON_SEL_RST; // R11
    end else if (wr_mon) begin
      monitor_select_register <= hwdata[4:0]; // R10 R13
    end
  end

  // Code registers, writable whatever the power mode
  genvar c;
  generate
    for (c = 0; c < `DCMC_NUM_CH; c = c + 1) begin : code_reg
      localparam [2:0] IDX = c;
      wire write_here;

      assign write_here = wr_q & hit_code & (code_index == IDX);
      // Stored code of this channel
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          code[c*16 +: 16] <= `DCMC_CODE_RST;
        end else if (write_here) begin
          code[c*16 +: 16] <= hwdata[15:0]; // R7 R8
        end
      end
    end
  endgenerate

  // Code word addressed by the data-phase address
  always @* begin
    code_word = code[code_index*16 +: 16];
  end

  // Status word of the output stages
  always @* begin
    status_word = {out_voltage_mode, out_enable};
  end

  // Source class of the stored monitor select
  always @* begin
    mon_src_channel = (monitor_select_register != `DCMC_MON_SEL_RST)
      && (monitor_select_register <= `DCMC_MON_CH_LAST); // R12
    mon_src_temp = (monitor_select_register == `DCMC_MON_TEMP); // R12
    mon_src_ground = (monitor_select_register == `DCMC_MON_LAST); // R12
  end

  // Read data mux, unmapped reads zero
  always @* begin
    next_rdata = 32'h0000_0000;
    if (hit_power) begin
      next_rdata = {16'h0000, channel_power_mode};
    end else if (hit_vout) begin
      next_rdata = {24'h00_0000, voltage_output_select};
    end else if (hit_range) begin
      next_rdata = {29'h0000_0000, range_bit, 2'b00};
    end else if (hit_ref) begin
      next_rdata = {31'h0000_0000, ref_bit};
    end else if (hit_mon) begin
      next_rdata = {27'h000_0000, monitor_select_register};
    end else if (hit_status) begin
      next_rdata = {16'h0000, status_word};
    end else if (hit_code) begin
      next_rdata = {16'h0000, code_word};
    end
  end

  // Read data registered at the end of the wait state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_q) begin
      hrdata <= next_rdata;
    end
  end

  // Channel output stage controls, one copy per channel
  genvar g;
  generate
    for (g = 0; g < `DCMC_NUM_CH; g = g + 1) begin : ch
      wire [1:0] mode_field;
      wire next_enable;
      wire next_pulldown;

      // Mode field of this channel and the pin state it asks for
      assign mode_field = channel_power_mode[g*2 +: 2];
      assign next_enable = (mode_field == `DCMC_MODE_NORMAL); // R2
      assign next_pulldown = ~next_enable & voltage_output_select[g]; // R3
      // Output stage state, code frozen while powered down
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          out_enable[g] <= 1'b0; // R1
          out_voltage_mode[g] <= 1'b0; // R1
          out_pulldown[g] <= 1'b0; // R1
          out_code[g*16 +: 16] <= `DCMC_CODE_RST;
        end else begin
          out_enable[g] <= next_enable; // R2
          out_voltage_mode[g] <= voltage_output_select[g]; // R4
          out_pulldown[g] <= next_pulldown; // R3
          if (next_enable) begin
            out_code[g*16 +: 16] <= code[g*16 +: 16]; // R7 R8
          end
        end
      end
    end
  endgenerate

  // Shared gain for all voltage channels
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_double <= `DCMC_RANGE_RST; // R6
    end else begin
      gain_double <= range_bit; // R6
    end
  end

  // Reference source, external after reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      internal_ref_en <= `DCMC_REF_RST; // R9
    end else begin
      internal_ref_en <= ref_bit; // R9
    end
  end

  // Monitor runs whenever a source is selected
  always @* begin
    next_monitor_enable = mon_src_channel | mon_src_temp | mon_src_ground; // R11
  end

  // Monitor enable and select, powered down after reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      monitor_enable <= 1'b0; // R11
      monitor_output <= `DCMC_MON_SEL_RST; // R11
    end else begin
      monitor_enable <= next_monitor_enable; // R11
      monitor_output <= monitor_select_register; // R12
    end
  end

endmodule // dcmc_top

// ==== hdl/dcmc_consts.vh ====
`ifndef DCMC_CONSTS_VH
`define DCMC_CONSTS_VH
// Register byte offsets
`define DCMC_OFF_POWER_MODE 12'h000
`define DCMC_OFF_VOUT_SEL 12'h004
`define DCMC_OFF_RANGE 12'h008
`define DCMC_OFF_REFERENCE 12'h00C
`define DCMC_OFF_MON_SEL 12'h010
`define DCMC_OFF_STATUS 12'h014
`define DCMC_OFF_CODE_BASE 12'h020
`define DCMC_OFF_CODE_LAST 12'h03C
// Field positions, widths and the channel count
`define DCMC_RANGE_BIT 2
`define DCMC_REF_SEL_BIT 0
`define DCMC_MODE_W 2
`define DCMC_NUM_CH 8
`define DCMC_CODE_W 16
`define DCMC_MON_W 5
// Reset values and the normal power mode
`define DCMC_POWER_MODE_RST 16'hFFFF
`define DCMC_VOUT_SEL_RST 8'h00
`define DCMC_MON_SEL_RST 5'h00
`define DCMC_CODE_RST 16'h0000
`define DCMC_MODE_NORMAL 2'b00
`define DCMC_RANGE_RST 1'b0
`define DCMC_REF_RST 1'b0
// Monitor select encodings
`define DCMC_MON_LAST 5'h1A
`define DCMC_MON_TEMP 5'h19
`define DCMC_MON_CH_LAST 5'h18
`endif

// ==== tb/dcmc_top_properties.sv ====
`timescale 1ns/1ps
module dcmc_chk (
  input wire hclk, input wire hresetn, input wire hsel, input wire hready, input wire hwrite,
  input wire [11:0] haddr, input wire [1:0] htrans, input wire [31:0] hwdata,
  input wire hreadyout, input wire hresp, input wire [7:0] out_enable,
  input wire [7:0] out_voltage_mode, input wire [7:0] out_pulldown, input wire [127:0] out_code,
  input wire gain_double, input wire internal_ref_en, input wire monitor_enable,
  input wire [4:0] monitor_output
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (!hresp) else $error("response not okay");
  a_wait_short: assert property (!hreadyout |=> hreadyout) else $error("wait state too long");
  a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout)
    else $error("read wait missing");
  a_pulldown_rule: assert property (out_pulldown == (out_voltage_mode & ~out_enable))
    else $error("pulldown wrong");
  a_mon_enable: assert property (monitor_enable == (monitor_output != 5'h00))
    else $error("monitor enable wrong");
  a_mon_range: assert property (monitor_output <= 5'h1A) else $error("monitor range");
  a_code_frozen: assert property (!out_enable[7] ##1 !out_enable[7] |-> $stable(out_code[127:112]))
    else $error("code moved");
  a_reset_ch: assert property ($rose(hresetn) |-> out_enable == 8'h00 && monitor_output == 5'h00)
    else $error("reset state");
  a_reset_cfg: assert property ($rose(hresetn) |-> !out_voltage_mode && !gain_double && !internal_ref_en)
    else $error("reset config");
  a_mon_hold: assert property (hsel && hready && htrans[1] && hwrite && haddr == 12'h010 ##1
    hwdata > 32'h0000_001A |-> ($stable(monitor_output))[*3]) else $error("bad select taken");
  cover property (out_pulldown != 8'h00);
  cover property (monitor_output == 5'h19);
  cover property (gain_double && internal_ref_en);
endmodule // dcmc_chk
bind dcmc_top dcmc_chk dcmc_chk_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .hready(hready), .hwrite(hwrite), .haddr(haddr), .htrans(htrans), .hwdata(hwdata),
  .hreadyout(hreadyout), .hresp(hresp), .out_enable(out_enable),
  .out_voltage_mode(out_voltage_mode), .out_pulldown(out_pulldown), .out_code(out_code),
  .gain_double(gain_double), .internal_ref_en(internal_ref_en),
  .monitor_enable(monitor_enable), .monitor_output(monitor_output));

// ==== tb/dcmc_host_model.sv ====
`timescale 1ns/1ps
module dcmc_host_model (
  input wire hclk,
  input wire hreadyout,
  input wire [31:0] hrdata,
  output reg hsel = 1'b1,
  output reg [11:0] haddr = 12'h000,
  output reg [1:0] htrans = 2'b00,
  output reg hwrite = 1'b0,
  output reg [2:0] hsize = 3'b010,
  output reg [31:0] hwdata = 32'h0000_0000
);
  // One word transfer, each phase held until ready is seen
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (!hreadyout);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
    q = hrdata;
    hwdata <= ~d; // Released data must not keep its value
  endtask
endmodule // dcmc_host_model

// ==== tb/dac_channel_mode_control_bench.sv ====
`timescale 1ns/1ps
module dac_channel_mode_control_bench;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  wire hsel, hwrite, hreadyout, hresp, gain_double, internal_ref_en, monitor_enable;
  wire [11:0] haddr;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [31:0] hwdata, hrdata;
  wire [7:0] out_enable, out_voltage_mode, out_pulldown;
  wire [127:0] out_code;
  wire [4:0] monitor_output;
  reg [31:0] rdv;
  integer n_mismatch = 0;
  integer num_checks = 0;
  always #2 hclk = ~hclk;
  dcmc_top dcmc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .out_enable(out_enable),
    .out_voltage_mode(out_voltage_mode), .out_pulldown(out_pulldown), .out_code(out_code),
    .gain_double(gain_double), .internal_ref_en(internal_ref_en),
    .monitor_enable(monitor_enable), .monitor_output(monitor_output));
  dcmc_host_model dcmc_host_model_inst (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata));
  // Compare one value
  task chk(input string nm, input [31:0] e, input [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Write, then let the outputs follow
  task wrc(input [11:0] a, input [31:0] d);
    dcmc_host_model_inst.xfer(1'b1, a, d, rdv);
    repeat (2) @(posedge hclk);
    #1;
  endtask
  task rdc(input [11:0] a, input [31:0] e);
    dcmc_host_model_inst.xfer(1'b0, a, 32'h0000_0000, rdv);
    chk("read", e, rdv);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog
  initial begin
    #20000;
    n_mismatch++;
    stop_test;
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(12'h000, 32'h0000_FFFF);
    rdc(12'h004, 32'h0000_0000);
    rdc(12'h00C, 32'h0000_0000);
    rdc(12'h010, 32'h0000_0000);
    chk("monen", 32'h0000_0000, {31'h0, monitor_enable});
    wrc(12'h000, 32'h0000_E400);
    chk("enable", 32'h0000_001F, {24'h0, out_enable});
    wrc(12'h004, 32'h0000_00F0);
    chk("vmode", 32'h0000_00F0, {24'h0, out_voltage_mode});
    chk("pulldown", 32'h0000_00E0, {24'h0, out_pulldown});
    rdc(12'h014, 32'h0000_F01F);
    wrc(12'h020, 32'h0000_1234);
    chk("code0", 32'h0000_1234, {16'h0, out_code[15:0]});
    wrc(12'h03C, 32'h0000_BEEF);
    chk("code7", 32'h0000_0000, {16'h0, out_code[127:112]});
    rdc(12'h03C, 32'h0000_BEEF);
    wrc(12'h008, 32'h0000_0004);
    chk("gain", 32'h0000_0001, {31'h0, gain_double});
    wrc(12'h00C, 32'h0000_0001);
    chk("ref", 32'h0000_0001, {31'h0, internal_ref_en});
    wrc(12'h010, 32'h0000_0019);
    chk("mon", 32'h0000_0019, {27'h0, monitor_output});
    chk("monen", 32'h0000_0001, {31'h0, monitor_enable});
    wrc(12'h010, 32'h0000_001B);
    chk("mon", 32'h0000_0019, {27'h0, monitor_output});
    wrc(12'h010, 32'h0000_003A);
    chk("mon", 32'h0000_0019, {27'h0, monitor_output});
    wrc(12'h010, 32'h0000_001A);
    chk("mon", 32'h0000_001A, {27'h0, monitor_output});
    rdc(12'h100, 32'h0000_0000);
    stop_test;
  end
endmodule // dac_channel_mode_control_bench
